// ---- verilog/strap_pkg.sv ----
// constants for the port and flash strap latch
package strap_pkg;
    // ==========================================
    // register map (byte addresses)
    localparam logic [11:0] addr_straps    = 12'h000;
    localparam logic [11:0] addr_control   = 12'h004;
    localparam logic [11:0] addr_status    = 12'h008;
    localparam logic [11:0] addr_irq_stat  = 12'h00c;
    localparam logic [11:0] addr_irq_mask  = 12'h010;
    // ==========================================
    // field positions
    localparam int straps_p2_plus    = 0;
    localparam int straps_p2_minus   = 1;
    localparam int straps_p3_plus    = 2;
    localparam int straps_p3_minus   = 3;
    localparam int straps_p4_plus    = 4;
    localparam int straps_p4_minus   = 5;
    localparam int straps_speed      = 6;
    localparam int straps_port_dis   = 8;
    localparam int ctrl_suspend      = 0;
    localparam int ctrl_powerdown    = 1;
    localparam int ctrl_flash_en     = 2;
    localparam int stat_oc1          = 0;
    localparam int stat_oc2          = 1;
    localparam int irq_oc1           = 0;
    localparam int irq_oc2           = 1;
    localparam int irq_width         = 2;
    // ==========================================
    // reset values and clock rates
    localparam logic [2:0] control_rst   = 3'h4;
    localparam logic [1:0] irq_mask_rst  = 2'h0;
    localparam int flash_clk_slow_mhz    = 30;
    localparam int flash_clk_fast_mhz    = 60;
    localparam logic [7:0] flash_clk_slow_code = 8'h1e;
    localparam logic [7:0] flash_clk_fast_code = 8'h3c;
    localparam int sync_stages           = 2;
endpackage

// ---- verilog/pin_sync.sv ----
// two flip-flop synchroniser for a group of pin inputs
`timescale 1ns/10ps
module pin_sync #(
    parameter int width = 1,
    parameter logic [width-1:0] rst_val = '0
) (
    input  wire logic             clk,    // device clock
    input  wire logic             reset,  // async, active high
    input  wire logic [width-1:0] d,      // raw pins
    output logic      [width-1:0] q       // synchronised level
);
    logic [width-1:0] meta_ff;

    // first stage feeds only the second
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            meta_ff <= rst_val;
            q       <= rst_val;
        end else begin
            meta_ff <= d;
            q       <= meta_ff;
        end
    end
endmodule

// ---- verilog/port_and_spi_strap_latch.sv ----
// strap latch, flash pin control and over-current sense with ahb-lite registers
// Summary of operation
// - strap low means enabled, high disabled
// - port off only when both straps high
// - speed strap low 30 MHz, high 60 MHz
// - speed high: release speed pin in suspend
// - speed low: drive speed pin low in suspend
// - chip enable held high in powerdown while flash enable is set
// - over-current inputs low mean fault
`timescale 1ns/10ps
module port_and_spi_strap_latch
    import strap_pkg::*;
(
    input  wire logic        clk,                        // 10 MHz device clock
    input  wire logic        reset,                      // async, active high
    input  wire logic        port2_plus_disable_strap,   // strap pin
    input  wire logic        port2_minus_disable_strap,  // strap pin
    input  wire logic        port3_plus_disable_strap,   // strap pin
    input  wire logic        port3_minus_disable_strap,  // strap pin
    input  wire logic        port4_plus_disable_strap,   // strap pin
    input  wire logic        port4_minus_disable_strap,  // strap pin
    input  wire logic        flash_speed_strap_in,       // speed pin level
    output logic             flash_speed_strap_out,      // speed pin drive value
    output logic             flash_speed_strap_oe,       // speed pin drive enable
    input  wire logic        port1_overcurrent_n,        // fault when low
    input  wire logic        port2_overcurrent_n,        // fault when low
    input  wire logic        flash_ce_n_core,            // chip enable from flash master
    output logic             flash_ce_n,                 // chip enable pin, active low
    output logic [2:0]       port_disable,               // ports 4..2 disabled
    output logic             straps_valid,               // straps latched
    output logic [7:0]       flash_clk_mhz,              // selected flash clock rate
    output logic [1:0]       overcurrent,                // ports 2..1 in fault
    output logic             irq,                        // level interrupt
    input  wire logic        hsel,                       // ahb select
    input  wire logic [31:0] haddr,                      // ahb address
    input  wire logic [1:0]  htrans,                     // ahb transfer type
    input  wire logic        hwrite,                     // ahb write
    input  wire logic [2:0]  hsize,                      // ahb size
    input  wire logic [31:0] hwdata,                     // ahb write data
    input  wire logic        hready,                     // ahb bus ready
    output logic [31:0]      hrdata,                     // ahb read data
    output logic             hreadyout,                  // ahb slave ready
    output logic             hresp                       // ahb response, always okay
);

    // ==========================================
    // register map, one aligned word each
    //   straps    ro   [5:0]  latched disable straps, port 2 plus first
    //                  [6]    latched speed strap
    //                  [10:8] ports 4..2 disabled
    //                  [8]    also carries straps valid, or-ed in
    //   control   rw   [0] suspend, [1] powerdown, [2] flash enable
    //   status    ro   [1:0] live fault of ports 2..1
    //   irq_stat  w1c  [1:0] fault onset of ports 2..1
    //   irq_mask  rw   [1:0] enables for irq_stat
    // control comes up with the flash master enabled and the chip awake;
    // unmapped reads return zero and unmapped writes are dropped
    // bit 8 of straps is shared, so port 2 is best judged from the pin
    // the strap bits read back the captured levels, not the live pins,
    // so software sees exactly what the port logic acts on
    // writes to the read-only words are ignored without an error

    // ==========================================
    // pin synchronisers
    // strap and monitor pins are asynchronous to clk; nothing reads
    // the first stage, so a metastable level never reaches logic
    logic [6:0] strap_sync;
    logic [1:0] oc_n_sync;

    pin_sync #(.width(7), .rst_val(7'h00)) u_strap_sync (
        .clk   (clk),
        .reset (reset),
        .d     ({flash_speed_strap_in, port4_minus_disable_strap, port4_plus_disable_strap,
                 port3_minus_disable_strap, port3_plus_disable_strap,
                 port2_minus_disable_strap, port2_plus_disable_strap}),
        .q     (strap_sync)
    );

    // pulled-up pins idle high, so reset to no fault
    pin_sync #(.width(2), .rst_val(2'h3)) u_oc_sync (
        .clk   (clk),
        .reset (reset),
        .d     ({port2_overcurrent_n, port1_overcurrent_n}),
        .q     (oc_n_sync)
    );

    // ==========================================
    // strap capture
    // the sync chain needs two edges after release; capture on the third.
    // the straps are read once, so a board that moves a strap later
    // changes nothing until the next reset
    // a short reset pulse is enough: the walk restarts on every reset
    typedef enum logic [1:0] {cap_sync1, cap_sync2, cap_take, cap_hold} capture_state_t;
    capture_state_t cap_state_ff;
    capture_state_t nxt_cap_state;
    logic           latched_ff;
    logic [6:0]     straps_ff;
    wire            capture_now = (cap_state_ff == cap_take);

    // walk the settle states, then park in hold
    always_comb begin
        case (cap_state_ff)
            cap_sync1: nxt_cap_state = cap_sync2;
            cap_sync2: nxt_cap_state = cap_take;
            cap_take:  nxt_cap_state = cap_hold;
            cap_hold:  nxt_cap_state = cap_hold;
            default:   nxt_cap_state = cap_hold;
        endcase
    end

    // sample once, then hold until the next reset
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            cap_state_ff <= cap_sync1;
            latched_ff   <= 1'b0;
            straps_ff    <= 7'h00;
        end else begin
            cap_state_ff <= nxt_cap_state;
            if (capture_now) begin
                latched_ff <= 1'b1;
                straps_ff  <= strap_sync;
            end
        end
    end

    // each line is disabled when high; the port only when both lines are
    // a single high strap is a board fault or a half-fitted option and
    // leaves the port running, which is the safer of the two outcomes
    function automatic logic pair_disabled(input logic plus_line, input logic minus_line);
        pair_disabled = plus_line & minus_line;
    endfunction

    wire [2:0] nxt_port_disable = {
        pair_disabled(straps_ff[straps_p4_plus], straps_ff[straps_p4_minus]),
        pair_disabled(straps_ff[straps_p3_plus], straps_ff[straps_p3_minus]),
        pair_disabled(straps_ff[straps_p2_plus], straps_ff[straps_p2_minus])};
    wire       speed_fast = straps_ff[straps_speed];
    wire [7:0] nxt_clk_mhz = speed_fast ? flash_clk_fast_code : flash_clk_slow_code;

    // ==========================================
    // ahb-lite slave, zero wait states
    logic        ctl_suspend_ff;
    logic        ctl_powerdown_ff;
    logic        ctl_flash_en_ff;
    logic [1:0]  irq_stat_ff;
    logic [1:0]  irq_mask_ff;
    logic        dp_write_ff;
    logic [11:0] dp_addr_ff;

    // read data is looked up in the address phase and registered, so it
    // stands for the whole data phase straight from a flop; the price is
    // that a read right behind a write to the same word sees the old value
    // hsize is not decoded: every register is one whole word
    wire [11:0] bus_addr   = {haddr[11:2], 2'b00};
    wire        addr_phase = hsel && hready && htrans[1];
    wire        rd_take    = addr_phase && !hwrite;
    wire        wr_ctl     = dp_write_ff && (dp_addr_ff == addr_control);
    wire        wr_istat   = dp_write_ff && (dp_addr_ff == addr_irq_stat);
    wire        wr_imask   = dp_write_ff && (dp_addr_ff == addr_irq_mask);

    // latch the write address phase for the following data phase
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            dp_write_ff <= 1'b0;
            dp_addr_ff  <= 12'h000;
        end else begin
            dp_write_ff <= addr_phase && hwrite;
            dp_addr_ff  <= bus_addr;
        end
    end

    // control register: suspend, powerdown and flash enable from software
    // suspend and powerdown are software's view of the chip power state;
    // nothing else moves them, so the pins stay parked until a new write
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            {ctl_flash_en_ff, ctl_powerdown_ff, ctl_suspend_ff} <= control_rst;
            irq_mask_ff <= irq_mask_rst;
        end else begin
            if (wr_ctl) begin
                ctl_suspend_ff   <= hwdata[ctrl_suspend];
                ctl_powerdown_ff <= hwdata[ctrl_powerdown];
                ctl_flash_en_ff  <= hwdata[ctrl_flash_en];
            end
            if (wr_imask) irq_mask_ff <= hwdata[irq_width-1:0];
        end
    end

    // ==========================================
    // over-current sense and sticky interrupt status
    // the inputs are pulled up, so an unwired monitor reads as no fault;
    // only the onset of a fault is latched, so a fault that stays present
    // does not raise the interrupt again after software clears it
    wire [1:0] fault_now = ~oc_n_sync;
    logic [1:0] fault_prev_ff;
    wire [1:0] fault_rise = fault_now & ~fault_prev_ff;
    wire [1:0] istat_clr  = wr_istat ? hwdata[irq_width-1:0] : 2'h0;
    // a new fault in the clearing cycle survives the clear
    wire [1:0] nxt_irq_stat = (irq_stat_ff & ~istat_clr) | fault_rise;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            fault_prev_ff <= 2'h0;
            irq_stat_ff   <= 2'h0;
        end else begin
            fault_prev_ff <= fault_now;
            irq_stat_ff   <= nxt_irq_stat;
        end
    end

    // ==========================================
    // read mux, looked up from the address phase
    // the two-bit registers are widened by one shared helper
    function automatic logic [31:0] word_of_pair(input logic [1:0] v);
        word_of_pair = {30'h0, v};
    endfunction

    wire [31:0] rd_straps = {23'h0, straps_valid, 1'b0, speed_fast, straps_ff[5:0]}
                          | {21'h0, port_disable, 8'h00};
    wire [31:0] rd_mux =
        (bus_addr == addr_straps)   ? rd_straps :
        (bus_addr == addr_control)  ? {29'h0, ctl_flash_en_ff, ctl_powerdown_ff, ctl_suspend_ff} :
        (bus_addr == addr_status)   ? word_of_pair(fault_now) :
        (bus_addr == addr_irq_stat) ? word_of_pair(irq_stat_ff) :
        (bus_addr == addr_irq_mask) ? word_of_pair(irq_mask_ff) :
                                      32'h0000_0000;  // unmapped reads zero

    // read data and the fixed slave answer, all from flops
    // outside a read data phase the bus sees zero, never stale data
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            hrdata    <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            hrdata    <= rd_take ? rd_mux : 32'h0000_0000;
            hreadyout <= 1'b1;                         // never inserts a wait
            hresp     <= 1'b0;                         // always okay
        end
    end

    // ==========================================
    // pin drivers and registered outputs
    // in suspend the speed pin is released or pulled low by its strap;
    // a fast board ties the pin high, so driving it low would fight the tie
    wire nxt_speed_oe  = ctl_suspend_ff && latched_ff && !speed_fast;
    // powerdown wins over the flash master while it is enabled; with the
    // master off the pin simply follows the core
    wire nxt_ce_n      = (ctl_flash_en_ff && ctl_powerdown_ff) ? 1'b1 : flash_ce_n_core;

    // flash pads, registered so they cannot glitch on decode changes
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            flash_speed_strap_out <= 1'b0;
            flash_speed_strap_oe  <= 1'b0;
            flash_ce_n            <= 1'b1;
        end else begin
            flash_speed_strap_out <= 1'b0;
            flash_speed_strap_oe  <= nxt_speed_oe;
            flash_ce_n            <= nxt_ce_n;
        end
    end

    // strap results, steady from one cycle after the capture
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            port_disable  <= 3'h0;
            straps_valid  <= 1'b0;
            flash_clk_mhz <= flash_clk_slow_code;
        end else begin
            port_disable  <= nxt_port_disable;
            straps_valid  <= latched_ff;
            flash_clk_mhz <= nxt_clk_mhz;
        end
    end

    // fault levels and the interrupt line
    // irq follows the next status value, so a clear drops it at once
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            overcurrent <= 2'h0;
            irq         <= 1'b0;
        end else begin
            overcurrent <= fault_now;
            irq         <= |(nxt_irq_stat & irq_mask_ff);
        end
    end
endmodule

// ---- testbench/strap_chk.sv ----
// port checker for the strap latch, bound to its top module
`timescale 1ns/10ps
module strap_chk
    import strap_pkg::*;
(
    input wire logic       clk,                        // clock
    input wire logic       reset,                      // async reset
    input wire logic       port2_plus_disable_strap,   // strap
    input wire logic       port2_minus_disable_strap,  // strap
    input wire logic       port3_plus_disable_strap,   // strap
    input wire logic       port3_minus_disable_strap,  // strap
    input wire logic       port4_plus_disable_strap,   // strap
    input wire logic       port4_minus_disable_strap,  // strap
    input wire logic       flash_speed_strap_in,       // speed pin
    input wire logic       flash_speed_strap_out,      // speed drive
    input wire logic       flash_speed_strap_oe,       // speed enable
    input wire logic       port1_overcurrent_n,        // monitor
    input wire logic       port2_overcurrent_n,        // monitor
    input wire logic       flash_ce_n_core,            // core enable
    input wire logic       flash_ce_n,                 // enable pin
    input wire logic [2:0] port_disable,               // ports off
    input wire logic       straps_valid,               // latched
    input wire logic [7:0] flash_clk_mhz,              // rate
    input wire logic [1:0] overcurrent,                // faults
    input wire logic       irq                         // interrupt
);
    // ====
    // properties, all in the one clock domain
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    property p_dis; $rose(straps_valid) |-> port_disable == {port4_plus_disable_strap & port4_minus_disable_strap,
        port3_plus_disable_strap & port3_minus_disable_strap, port2_plus_disable_strap & port2_minus_disable_strap};
    endproperty
    a_dis: assert property (p_dis) else $error("port disable wrong");
    property p_clk; $rose(straps_valid) |->
        flash_clk_mhz == (flash_speed_strap_in ? flash_clk_fast_code : flash_clk_slow_code); endproperty
    a_clk: assert property (p_clk) else $error("flash rate wrong");
    property p_rel; flash_clk_mhz == flash_clk_fast_code |-> !flash_speed_strap_oe; endproperty
    a_rel: assert property (p_rel) else $error("fast strap pin driven");
    property p_low; flash_speed_strap_oe |-> !flash_speed_strap_out && flash_clk_mhz == flash_clk_slow_code; endproperty
    a_low: assert property (p_low) else $error("speed pin not driven low");
    property p_ce; $fell(flash_ce_n) |-> !$past(flash_ce_n_core); endproperty
    a_ce: assert property (p_ce) else $error("chip enable fell alone");
    property p_oc1; (!port1_overcurrent_n) [*4] |-> overcurrent[0]; endproperty
    a_oc1: assert property (p_oc1) else $error("port1 fault missed");
    property p_oc2; port2_overcurrent_n [*4] |-> !overcurrent[1]; endproperty
    a_oc2: assert property (p_oc2) else $error("port2 false fault");
    property p_hold; straps_valid |=> straps_valid && $stable(port_disable) && $stable(flash_clk_mhz); endproperty
    a_hold: assert property (p_hold) else $error("latched straps moved");
    // main scenarios reached
    c_dis: cover property ($rose(straps_valid) && port_disable == 3'h7);
    c_sus: cover property (flash_speed_strap_oe);
    c_irq: cover property ($rose(irq));
endmodule
bind port_and_spi_strap_latch strap_chk chk_u (.*);

// ---- testbench/strap_board.sv ----
// board model: strap ties, speed pin wire and current monitors
`timescale 1ns/10ps
module strap_board (
    input  wire logic [6:0] tie,                        // tie levels
    input  wire logic [1:0] fault,                      // monitor faults
    input  wire logic       flash_speed_strap_out,      // device value
    input  wire logic       flash_speed_strap_oe,       // device enable
    output logic            port2_plus_disable_strap,   // pin
    output logic            port2_minus_disable_strap,  // pin
    output logic            port3_plus_disable_strap,   // pin
    output logic            port3_minus_disable_strap,  // pin
    output logic            port4_plus_disable_strap,   // pin
    output logic            port4_minus_disable_strap,  // pin
    output logic            flash_speed_strap_in,       // wire level
    output logic            port1_overcurrent_n,        // monitor pin
    output logic            port2_overcurrent_n         // monitor pin
);
    // a port is off only with both ties high
    assign {port4_minus_disable_strap, port4_plus_disable_strap, port3_minus_disable_strap} = tie[5:3];
    assign {port3_plus_disable_strap, port2_minus_disable_strap, port2_plus_disable_strap} = tie[2:0];
    // tie resistor beats the weak pull-down once released
    assign flash_speed_strap_in = flash_speed_strap_oe ? flash_speed_strap_out : tie[6];
    // monitors pull low on a fault
    assign port1_overcurrent_n = ~fault[0];
    assign port2_overcurrent_n = ~fault[1];
endmodule

// ---- testbench/port_and_spi_strap_latch_tb.sv ----
// self-checking bench for the strap latch
`timescale 1ns/10ps
module port_and_spi_strap_latch_tb;
    import strap_pkg::*;
    logic        clk = 1'b0, reset = 1'b1, flash_ce_n_core = 1'b1, hsel = 1'b0, hwrite = 1'b0;
    logic        flash_speed_strap_out, flash_speed_strap_oe, flash_ce_n, straps_valid, irq, hreadyout, hresp;
    logic        flash_speed_strap_in, port1_overcurrent_n, port2_overcurrent_n, hready;
    logic        port2_plus_disable_strap, port2_minus_disable_strap, port3_plus_disable_strap;
    logic        port3_minus_disable_strap, port4_plus_disable_strap, port4_minus_disable_strap;
    logic [1:0]  htrans = 2'h0, fault = 2'h0, f, msk, overcurrent;
    logic [2:0]  hsize = 3'h2, port_disable, ed;
    logic [6:0]  tie = 7'h0, pat;
    logic [7:0]  flash_clk_mhz;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
    int          errors = 0, n_checks = 0, seed = 71, k;
    port_and_spi_strap_latch dut_u (.*);
    strap_board board_u (.*);
    assign hready = hreadyout;
    always #50 clk = ~clk;
    // ====
    // expectations and shared tasks
    function automatic logic [2:0] exp_dis(input logic [6:0] t);
        return {t[5] & t[4], t[3] & t[2], t[1] & t[0]};
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // next edge with hready high, bounded
    task automatic rdy;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (hready !== 1'b1 && k < 20);
        if (hready !== 1'b1) begin
            errors++;
            test_done;
        end
    endtask
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] wd);
        @(posedge clk);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr  <= {20'h0, a};
        rdy;
        htrans <= 2'h0;
        hsel   <= 1'b0;
        hwdata <= wd;
        rdy;
        rd = hrdata;
    endtask
    // ====
    // corner straps first, then random ones
    initial begin
        for (int i = 0; i < 8; i++) begin
            pat = (i == 0) ? 7'h3f : (i == 1) ? 7'h55 : 7'($random(seed));
            {msk, f} = 4'($random(seed)) | 4'h1;
            ed = exp_dis(pat);
            reset <= 1'b1;
            tie   <= pat;
            repeat (3) @(posedge clk);
            reset <= 1'b0;
            for (k = 0; k < 20 && straps_valid !== 1'b1; k++) @(posedge clk);
            chk(straps_valid, 1'b1);
            if (straps_valid !== 1'b1) test_done;
            chk({port_disable, flash_clk_mhz}, {ed, pat[6] ? flash_clk_fast_code : flash_clk_slow_code});
            bus(1'b0, addr_straps, 32'h0);
            chk({rd[10:9], rd[6:0]}, {ed[2:1], pat});
            tie <= ~pat;
            bus(1'b1, addr_control, 32'h5);
            repeat (2) @(posedge clk);
            chk({flash_speed_strap_oe, flash_speed_strap_out}, {~pat[6], 1'b0});
            flash_ce_n_core <= 1'b0;
            bus(1'b1, addr_control, 32'h6);
            repeat (2) @(posedge clk);
            chk({flash_speed_strap_oe, flash_ce_n, port_disable}, {2'b01, ed});
            bus(1'b1, addr_control, 32'h2);
            repeat (2) @(posedge clk);
            chk(flash_ce_n, 1'b0);
            flash_ce_n_core <= 1'b1;
            bus(1'b1, addr_irq_mask, {30'h0, msk});
            fault <= f;
            repeat (5) @(posedge clk);
            chk({overcurrent, irq}, {f, |(f & msk)});
            bus(1'b0, addr_status, 32'h0);
            chk(rd, {30'h0, f});
            fault <= 2'h0;
            repeat (5) @(posedge clk);
            chk({overcurrent, irq}, {2'h0, |(f & msk)});
            bus(1'b1, addr_irq_stat, 32'h3);
            bus(1'b0, addr_irq_stat, 32'h0);
            chk(rd, 32'h0);
            chk(irq, 1'b0);
            bus(1'b0, 12'h020, 32'h0);
            chk(rd, 32'h0);
            chk({hreadyout, hresp}, 2'b10);
            $display("test %0d done", i);
        end
        test_done;
    end
endmodule
